// >>> rtl/tcu_pkg.sv
package tcu_pkg;

   // ==========================================================
   // register addresses
   localparam logic [7:0] ADR_TIMER_CONTROL_FLAGS  = 8'h88;
   localparam logic [7:0] ADR_TIMER_MODE_SELECT  = 8'h89;
   localparam logic [7:0] ADR_TL0   = 8'h8a;
   localparam logic [7:0] ADR_TL1   = 8'h8b;
   localparam logic [7:0] ADR_TH0   = 8'h8c;
   localparam logic [7:0] ADR_TH1   = 8'h8d;
   localparam logic [7:0] ADR_TIMER2_CONTROL = 8'hc9;
   localparam logic [7:0] ADR_RL2L  = 8'hca;
   localparam logic [7:0] ADR_RL2H  = 8'hcb;
   localparam logic [7:0] ADR_TL2   = 8'hcc;
   localparam logic [7:0] ADR_TH2   = 8'hcd;

   // ==========================================================
   // shared control register fields
   localparam int TC_TF1 = 7;
   localparam int TC_TR1 = 6;
   localparam int TC_TF0 = 5;
   localparam int TC_TR0 = 4;
   localparam int TC_IE1 = 3;
   localparam int TC_IT1 = 2;
   localparam int TC_IE0 = 1;
   localparam int TC_IT0 = 0;
   localparam logic [7:0] TIMER_CONTROL_FLAGS_RST = 8'h00;

   // ==========================================================
   // mode register fields
   localparam int TM_GATE1 = 7;
   localparam int TM_FN1   = 6;
   localparam int TM_M1_LO = 4;
   localparam int TM_GATE0 = 3;
   localparam int TM_FN0   = 2;
   localparam int TM_M0_LO = 0;
   localparam logic [7:0] TIMER_MODE_SELECT_RST = 8'h00;

   // ==========================================================
   // timer 2 control fields
   localparam int T2_TF  = 7;
   localparam int T2_RUN = 2;
   localparam int T2_FN  = 1;
   localparam logic [7:0] TIMER2_CONTROL_RST   = 8'h00;
   localparam logic [7:0] TIMER2_CONTROL_WMASK = 8'h06;
   localparam logic [7:0] COUNT_RST   = 8'h00;

   // ==========================================================
   // count structures and tick rate
   localparam logic [1:0] MODE_13    = 2'b00;
   localparam logic [1:0] MODE_16    = 2'b01;
   localparam logic [1:0] MODE_RLD   = 2'b10;
   localparam logic [1:0] MODE_SPLIT = 2'b11;
   localparam int         OSC_PER_TICK = 12;
   localparam logic [3:0] TICK_LAST = 4'(OSC_PER_TICK - 1);

   // ==========================================================
   // carriers
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tcu_sfr_s;

   typedef struct packed {
      logic t2;
      logic t1;
      logic t0;
      logic ex1;
      logic ex0;
   } tcu_ack_s;

   typedef struct packed {
      logic t2_ovf;
      logic t1_ovf;
      logic t0_ovf;
      logic ext1;
      logic ext0;
   } tcu_flags_s;

   typedef struct packed {
      logic       ovf;
      logic [7:0] hi;
      logic [7:0] lo;
   } tcu_cnt_s;

endpackage

// >>> rtl/tcu_prescaler.sv
`timescale 1ns/100ps
module tcu_prescaler (
   input  wire logic clk_i,
   input  wire logic rst_i,
   output logic      tick_o
);
   import tcu_pkg::*;

   logic [3:0] div_r;

   // ==========================================================
   // divide the oscillator by twelve, never held off
   // free running tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r  <= 4'h0;
         tick_o <= 1'b0;
      end else begin
         div_r  <= (div_r == TICK_LAST) ? 4'h0 : div_r + 4'h1;
         tick_o <= (div_r == TICK_LAST);
      end
   end
endmodule

// >>> rtl/tcu_pin_sampler.sv
`timescale 1ns/100ps
module tcu_pin_sampler (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic tick_i,
   input  wire logic pin_i,
   output logic      fall_o
);
   logic smp_r;
   logic old_r;

   // ==========================================================
   // take one sample per tick, keep the previous one
   // sample each tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         smp_r <= 1'b0;
         old_r <= 1'b0;
      end else if (tick_i) begin
         smp_r <= pin_i;
         old_r <= smp_r;
      end
   end

   // count on the tick after a one-then-zero pair
   // one per two samples
   assign fall_o = tick_i & old_r & ~smp_r;
endmodule

// >>> rtl/tcu_timers.sv
`timescale 1ns/100ps
module tcu_timers (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire tcu_pkg::tcu_sfr_s sfr_i,
   input  wire tcu_pkg::tcu_ack_s ack_i,
   input  wire logic              ext0_interrupt_pin_i,
   input  wire logic              ext1_interrupt_pin_i,
   input  wire logic              timer0_count_input_i,
   input  wire logic              timer1_count_input_i,
   input  wire logic              timer2_count_input_i,
   output logic [7:0]             sfr_rdata_o,
   output tcu_pkg::tcu_flags_s    flags_o
);
   import tcu_pkg::*;

   // ==========================================================
   // one count step of a timer 0/1 unit in its mode
   function automatic tcu_cnt_s step(input logic [1:0] m,
                                     input logic [7:0] hi,
                                     input logic [7:0] lo,
                                     input logic       inc);
      tcu_cnt_s r;
      r.ovf = 1'b0;
      r.hi  = hi;
      r.lo  = lo;
      if (inc) begin
         case (m)
            MODE_13: begin
               r.lo[4:0] = lo[4:0] + 5'h01;
               if (lo[4:0] == 5'h1f) begin
                  r.hi  = hi + 8'h01;
                  r.ovf = (hi == 8'hff);
               end
            end
            MODE_16: begin
               {r.hi, r.lo} = {hi, lo} + 16'h0001;
               r.ovf = ({hi, lo} == 16'hffff);
            end
            MODE_RLD: begin
               r.lo  = (lo == 8'hff) ? hi : lo + 8'h01;
               r.ovf = (lo == 8'hff);
            end
            default: begin
               // split mode: low byte alone here
               r.lo  = lo + 8'h01;
               r.ovf = (lo == 8'hff);
            end
         endcase
      end
      return r;
   endfunction

   // ==========================================================
   // state
   logic [7:0] timer_control_flags_r;
   logic [7:0] timer_mode_select_r;
   logic [7:0] timer2_control_r;
   logic [7:0] tl0_r;
   logic [7:0] th0_r;
   logic [7:0] tl1_r;
   logic [7:0] th1_r;
   logic [7:0] tl2_r;
   logic [7:0] th2_r;
   logic [7:0] rl2l_r;
   logic [7:0] rl2h_r;
   logic       ext0_d_r;
   logic       ext1_d_r;

   // ==========================================================
   // tick and pin samplers
   logic tick;
   logic fall0;
   logic fall1;
   logic fall2;

   tcu_prescaler u_presc (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (tick)
   );

   tcu_pin_sampler u_smp0 (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_i (tick),
      .pin_i  (timer0_count_input_i),
      .fall_o (fall0)
   );

   tcu_pin_sampler u_smp1 (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_i (tick),
      .pin_i  (timer1_count_input_i),
      .fall_o (fall1)
   );

   tcu_pin_sampler u_smp2 (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_i (tick),
      .pin_i  (timer2_count_input_i),
      .fall_o (fall2)
   );

   // ==========================================================
   // register write decode
   logic       wr_timer_control_flags;
   logic       wr_timer_mode_select;
   logic       wr_timer2_control;
   logic       wr_tl0;
   logic       wr_th0;
   logic       wr_tl1;
   logic       wr_th1;
   logic       wr_tl2;
   logic       wr_th2;
   logic       wr_rl2l;
   logic       wr_rl2h;
   logic [7:0] wd;

   assign wr_tl0   = sfr_i.wr & (sfr_i.addr == ADR_TL0);
   assign wr_th0   = sfr_i.wr & (sfr_i.addr == ADR_TH0);
   assign wr_tl1   = sfr_i.wr & (sfr_i.addr == ADR_TL1);
   assign wr_th1   = sfr_i.wr & (sfr_i.addr == ADR_TH1);
   assign wr_tl2   = sfr_i.wr & (sfr_i.addr == ADR_TL2);
   assign wr_th2   = sfr_i.wr & (sfr_i.addr == ADR_TH2);
   assign wr_rl2l  = sfr_i.wr & (sfr_i.addr == ADR_RL2L);
   assign wr_rl2h  = sfr_i.wr & (sfr_i.addr == ADR_RL2H);
   assign wr_timer_control_flags  = sfr_i.wr & (sfr_i.addr == ADR_TIMER_CONTROL_FLAGS);
   assign wr_timer_mode_select  = sfr_i.wr & (sfr_i.addr == ADR_TIMER_MODE_SELECT);
   assign wr_timer2_control = sfr_i.wr & (sfr_i.addr == ADR_TIMER2_CONTROL);
   assign wd       = sfr_i.wdata;

   // ==========================================================
   // mode fields and count enables
   logic [1:0] m0;
   logic [1:0] m1;
   logic       split;
   logic       en0;
   logic       en1;
   logic       inc0;
   logic       inc1;
   logic       inc_th0;

   assign m0    = timer_mode_select_r[TM_M0_LO +: 2];
   assign m1    = timer_mode_select_r[TM_M1_LO +: 2];
   assign split = (m0 == MODE_SPLIT);

   assign en0 = timer_control_flags_r[TC_TR0]
              & (~timer_mode_select_r[TM_GATE0] | ext0_interrupt_pin_i);
   assign en1 = timer_control_flags_r[TC_TR1]
              & (~timer_mode_select_r[TM_GATE1] | ext1_interrupt_pin_i);

   assign inc0 = en0 & (timer_mode_select_r[TM_FN0] ? fall0 : tick);
   assign inc1 = en1 & (m1 != MODE_SPLIT)
               & (timer_mode_select_r[TM_FN1] ? fall1 : tick);
   // high byte timer-only on run 1
   assign inc_th0 = split & timer_control_flags_r[TC_TR1] & tick;

   // ==========================================================
   // count steps
   tcu_cnt_s s0;
   tcu_cnt_s s1;
   logic     th0_ovf;

   assign s0      = step(m0, th0_r, tl0_r, inc0);
   assign s1      = step(m1, th1_r, tl1_r, inc1);
   assign th0_ovf = inc_th0 & (th0_r == 8'hff);

   // ==========================================================
   // timer 2 step with reload on overflow
   logic        en2;
   logic        inc2;
   logic [15:0] c2_inc;
   logic        ovf2;

   assign en2    = timer2_control_r[T2_RUN];
   assign inc2   = en2 & (timer2_control_r[T2_FN] ? fall2 : tick);
   assign c2_inc = {th2_r, tl2_r} + 16'h0001;
   assign ovf2   = inc2 & ({th2_r, tl2_r} == 16'hffff);

   // ==========================================================
   // count byte next values, a write overrides the step
   logic [7:0] tl0_nxt;
   logic [7:0] th0_nxt;
   logic [7:0] tl1_nxt;
   logic [7:0] th1_nxt;
   logic [7:0] tl2_nxt;
   logic [7:0] th2_nxt;
   logic [7:0] th0_run;
   logic [7:0] tl2_run;
   logic [7:0] th2_run;

   assign th0_run = split ? th0_r + {7'h00, inc_th0} : s0.hi;
   assign tl2_run = ovf2 ? rl2l_r : (inc2 ? c2_inc[7:0]  : tl2_r);
   assign th2_run = ovf2 ? rl2h_r : (inc2 ? c2_inc[15:8] : th2_r);

   assign tl0_nxt = wr_tl0 ? wd : s0.lo;
   assign th0_nxt = wr_th0 ? wd : th0_run;
   assign tl1_nxt = wr_tl1 ? wd : s1.lo;
   assign th1_nxt = wr_th1 ? wd : s1.hi;
   assign tl2_nxt = wr_tl2 ? wd : tl2_run;
   assign th2_nxt = wr_th2 ? wd : th2_run;

   // ==========================================================
   // external interrupt detection
   logic ie0_set;
   logic ie1_set;

   assign ie0_set = timer_control_flags_r[TC_IT0]
                  ? (ext0_d_r & ~ext0_interrupt_pin_i)
                  : ~ext0_interrupt_pin_i;
   assign ie1_set = timer_control_flags_r[TC_IT1]
                  ? (ext1_d_r & ~ext1_interrupt_pin_i)
                  : ~ext1_interrupt_pin_i;

   // ==========================================================
   // flag next values, a set beats a service clear
   logic tf0_nxt;
   logic tf1_nxt;
   logic tf2_nxt;
   logic ie0_nxt;
   logic ie1_nxt;

   assign tf0_nxt = s0.ovf | (timer_control_flags_r[TC_TF0] & ~ack_i.t0);
   // timer 1 flag, split mode takes it
   assign tf1_nxt = (split ? th0_ovf : s1.ovf)
                  | (timer_control_flags_r[TC_TF1] & ~ack_i.t1);
   assign ie0_nxt = ie0_set | (timer_control_flags_r[TC_IE0] & ~ack_i.ex0);
   assign ie1_nxt = ie1_set | (timer_control_flags_r[TC_IE1] & ~ack_i.ex1);
   assign tf2_nxt = ovf2 | (timer2_control_r[T2_TF] & ~ack_i.t2);

   // ==========================================================
   // control register next values
   logic [7:0] timer_control_flags_nxt;
   logic [7:0] timer_mode_select_nxt;
   logic [7:0] timer2_control_nxt;
   logic [7:0] timer_control_flags_src;
   logic [7:0] t2_keep;

   assign timer_control_flags_src = wr_timer_control_flags ? wd : timer_control_flags_r;
   assign timer_control_flags_nxt = {tf1_nxt, timer_control_flags_src[TC_TR1],
                      tf0_nxt, timer_control_flags_src[TC_TR0],
                      ie1_nxt, timer_control_flags_src[TC_IT1],
                      ie0_nxt, timer_control_flags_src[TC_IT0]};
   assign timer_mode_select_nxt = wr_timer_mode_select ? wd : timer_mode_select_r;
   assign t2_keep  = (wr_timer2_control ? wd : timer2_control_r) & TIMER2_CONTROL_WMASK;
   assign timer2_control_nxt = t2_keep | {tf2_nxt, 7'h00};

   // ==========================================================
   // control and status registers
   // shared control reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_control_flags_r   <= TIMER_CONTROL_FLAGS_RST;
         timer_mode_select_r   <= TIMER_MODE_SELECT_RST;
         timer2_control_r  <= TIMER2_CONTROL_RST;
         ext0_d_r <= 1'b1;
         ext1_d_r <= 1'b1;
      end else begin
         timer_control_flags_r   <= timer_control_flags_nxt;
         timer_mode_select_r   <= timer_mode_select_nxt;
         timer2_control_r  <= timer2_control_nxt;
         ext0_d_r <= ext0_interrupt_pin_i;
         ext1_d_r <= ext1_interrupt_pin_i;
      end
   end

   // ==========================================================
   // count and reload bytes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tl0_r  <= COUNT_RST;
         th0_r  <= COUNT_RST;
         tl1_r  <= COUNT_RST;
         th1_r  <= COUNT_RST;
         tl2_r  <= COUNT_RST;
         th2_r  <= COUNT_RST;
         rl2l_r <= COUNT_RST;
         rl2h_r <= COUNT_RST;
      end else begin
         tl0_r  <= tl0_nxt;
         th0_r  <= th0_nxt;
         tl1_r  <= tl1_nxt;
         th1_r  <= th1_nxt;
         tl2_r  <= tl2_nxt;
         th2_r  <= th2_nxt;
         rl2l_r <= wr_rl2l ? wd : rl2l_r;
         rl2h_r <= wr_rl2h ? wd : rl2h_r;
      end
   end

   // ==========================================================
   // read selection, unmapped addresses read zero
   logic [7:0] rd_mux;

   assign rd_mux =
      (sfr_i.addr == ADR_TIMER_CONTROL_FLAGS)  ? timer_control_flags_r  :
      (sfr_i.addr == ADR_TIMER_MODE_SELECT)  ? timer_mode_select_r  :
      (sfr_i.addr == ADR_TIMER2_CONTROL) ? timer2_control_r :
      (sfr_i.addr == ADR_TL0)   ? tl0_r   :
      (sfr_i.addr == ADR_TH0)   ? th0_r   :
      (sfr_i.addr == ADR_TL1)   ? tl1_r   :
      (sfr_i.addr == ADR_TH1)   ? th1_r   :
      (sfr_i.addr == ADR_TL2)   ? tl2_r   :
      (sfr_i.addr == ADR_TH2)   ? th2_r   :
      (sfr_i.addr == ADR_RL2L)  ? rl2l_r  :
      (sfr_i.addr == ADR_RL2H)  ? rl2h_r  : 8'h00;

   // ==========================================================
   // registered outputs: read data and flags for the core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sfr_rdata_o <= 8'h00;
         flags_o     <= '0;
      end else begin
         sfr_rdata_o    <= rd_mux;
         flags_o.t2_ovf <= tf2_nxt;
         flags_o.t1_ovf <= tf1_nxt;
         flags_o.t0_ovf <= tf0_nxt;
         flags_o.ext1   <= ie1_nxt;
         flags_o.ext0   <= ie0_nxt;
      end
   end
endmodule

// >>> tb/tcu_pin_source.sv
`timescale 1ns/100ps
// ==========================================
// outside logic toggling a counter pin
module tcu_pin_source #(
   parameter int HALF = 12
) (
   input  wire logic clk_i,
   input  wire logic en_i,
   output logic      pin_o
);
   int cnt_r;

   initial pin_o = 1'b1;

   // each level held one sample period
   always @(posedge clk_i) begin
      if (!en_i) begin
         cnt_r <= 0;
         pin_o <= 1'b1;
      end else if (cnt_r == HALF - 1) begin
         cnt_r <= 0;
         pin_o <= ~pin_o;
      end else begin
         cnt_r <= cnt_r + 1;
      end
   end
endmodule

// >>> tb/tcu_timers_checker.sv
`timescale 1ns/100ps
// ==========================================
// port-level checks of the timer block
module tcu_timers_checker (
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire tcu_pkg::tcu_sfr_s   sfr_i,
   input wire tcu_pkg::tcu_ack_s   ack_i,
   input wire logic                ext0_interrupt_pin_i,
   input wire logic                ext1_interrupt_pin_i,
   input wire logic                timer0_count_input_i,
   input wire logic                timer1_count_input_i,
   input wire logic                timer2_count_input_i,
   input wire logic [7:0]          sfr_rdata_o,
   input wire tcu_pkg::tcu_flags_s flags_o
);
   import tcu_pkg::*;
   logic       it0_r;
   logic       it1_r;
   logic [4:0] fl_r;
   wire        tc_wr = sfr_i.wr && (sfr_i.addr == ADR_TIMER_CONTROL_FLAGS);
   wire        mapped_w = (sfr_i.addr >= ADR_TIMER_CONTROL_FLAGS && sfr_i.addr <= ADR_TH1)
                       || (sfr_i.addr >= ADR_TIMER2_CONTROL && sfr_i.addr <= ADR_TH2);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // track trigger bits and last flags
   always_ff @(posedge clk_i) begin
      fl_r <= flags_o;
      if (rst_i) begin
         it0_r <= 1'b0;
         it1_r <= 1'b0;
      end else if (tc_wr) begin
         it0_r <= sfr_i.wdata[TC_IT0];
         it1_r <= sfr_i.wdata[TC_IT1];
      end
   end

   sequence tc_write_s;
      tc_wr ##1 (!sfr_i.wr && sfr_i.addr == ADR_TIMER_CONTROL_FLAGS);
   endsequence

   sequence ext1_quiet_s;
      ext1_interrupt_pin_i [*5];
   endsequence

   chk_reset_clears: assert property (
      disable iff (1'b0) rst_i |=> sfr_rdata_o == 8'h00 && flags_o == '0)
      else $error("outputs not cleared by reset");
   chk_timer_control_flags_write: assert property (
      tc_write_s |=> (sfr_rdata_o & 8'h55) == ($past(sfr_i.wdata, 2) & 8'h55))
      else $error("control write not read back");
   chk_flag_mirror: assert property (
      $past(sfr_i.addr) == ADR_TIMER_CONTROL_FLAGS && !$past(rst_i) |->
      {sfr_rdata_o[7], sfr_rdata_o[5], sfr_rdata_o[3], sfr_rdata_o[1]}
      == fl_r[3:0])
      else $error("control flags differ from flag outputs");
   chk_unmapped_zero: assert property (
      !$past(mapped_w) && !$past(rst_i) |-> sfr_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_t0_flag_kept: assert property (
      $fell(flags_o.t0_ovf) && !$past(rst_i) |-> $past(ack_i.t0))
      else $error("timer 0 flag cleared without service");
   chk_edge_flag: assert property (
      it0_r && $fell(ext0_interrupt_pin_i) |-> ##[1:2] flags_o.ext0)
      else $error("falling edge did not set flag");
   chk_level_flag: assert property (
      !it1_r && !ext1_interrupt_pin_i |-> ##[1:2] flags_o.ext1)
      else $error("low level did not set flag");
   chk_ack_clears: assert property (
      ext1_quiet_s ##0 (it1_r && ack_i.ex1) |=> !flags_o.ext1)
      else $error("service did not clear flag");
endmodule

bind tcu_timers tcu_timers_checker u_chk (
   .clk_i                (clk_i),
   .rst_i                (rst_i),
   .sfr_i                (sfr_i),
   .ack_i                (ack_i),
   .ext0_interrupt_pin_i (ext0_interrupt_pin_i),
   .ext1_interrupt_pin_i (ext1_interrupt_pin_i),
   .timer0_count_input_i (timer0_count_input_i),
   .timer1_count_input_i (timer1_count_input_i),
   .timer2_count_input_i (timer2_count_input_i),
   .sfr_rdata_o          (sfr_rdata_o),
   .flags_o              (flags_o)
);

// >>> tb/standard_timer_counters_tb.sv
`timescale 1ns/100ps
module standard_timer_counters_tb;
   import tcu_pkg::*;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rexp;
   } tcu_row_s;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   tcu_sfr_s   sfr = '0;
   tcu_ack_s   ack = '0;
   logic       ex0 = 1'b1;
   logic       ex1 = 1'b1;
   logic       src_en = 1'b0;
   logic       pin;
   logic [7:0] rdata;
   tcu_flags_s flags;
   logic [7:0] got;
   int         fail_count = 0;
   int         compares = 0;
   int         cycles = 0;
   logic [7:0] cnt_adr [3] = '{ADR_TL0, ADR_TL1, ADR_TL2};
   tcu_row_s   rows [12] = '{
      '{ADR_TIMER_MODE_SELECT, 8'ha5, 8'ha5}, '{ADR_TL0, 8'h12, 8'h12},
      '{ADR_TH0, 8'h34, 8'h34}, '{ADR_TL1, 8'h56, 8'h56},
      '{ADR_TH1, 8'h78, 8'h78}, '{ADR_RL2L, 8'h9a, 8'h9a},
      '{ADR_RL2H, 8'hbc, 8'hbc}, '{ADR_TL2, 8'hde, 8'hde},
      '{ADR_TH2, 8'hf0, 8'hf0}, '{ADR_TIMER2_CONTROL, 8'hff, 8'h06},
      '{ADR_TIMER_CONTROL_FLAGS, 8'hff, 8'h55}, '{8'h80, 8'h5a, 8'h00}};

   tcu_timers DUT (
      .clk_i                (clk_i),
      .rst_i                (rst_i),
      .sfr_i                (sfr),
      .ack_i                (ack),
      .ext0_interrupt_pin_i (ex0),
      .ext1_interrupt_pin_i (ex1),
      .timer0_count_input_i (pin),
      .timer1_count_input_i (pin),
      .timer2_count_input_i (pin),
      .sfr_rdata_o          (rdata),
      .flags_o              (flags)
   );

   tcu_pin_source #(.HALF(12)) u_src (
      .clk_i (clk_i),
      .en_i  (src_en),
      .pin_o (pin)
   );

   // ==========================================
   // clock, timeout and bus tasks
   always #10 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr.wr <= 1'b1;
      sfr.addr <= a;
      sfr.wdata <= d;
      @(posedge clk_i);
      sfr.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      sfr.addr <= a;
      repeat (2) @(posedge clk_i);
      #1 got = rdata;
   endtask

   task automatic check_rng(input logic [7:0] lo, input logic [7:0] hi);
      compares++;
      if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
         fail_count++;
         $display("unexpected at %0t: got %h, range %h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic check(input logic [7:0] exp);
      check_rng(exp, exp);
   endtask

   task automatic pulse_ack(input tcu_ack_s a);
      @(posedge clk_i);
      ack <= a;
      @(posedge clk_i);
      ack <= '0;
   endtask

   task automatic conclude;
      $display("compares %0d, fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values of every register
      foreach (rows[i]) begin
         rd(rows[i].addr);
         check(8'h00);
      end
      // write and read back, masked bits and unmapped place
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr);
         check(rows[i].rexp);
      end
      // timer rate over 600 clocks
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h05);
      wr(ADR_TIMER_MODE_SELECT, 8'h01);
      wr(ADR_TL0, 8'h00);
      wr(ADR_TH0, 8'h00);
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h15);
      repeat (600) @(posedge clk_i);
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h05);
      rd(ADR_TL0);
      check_rng(8'd49, 8'd51);
      // 16-bit overflow, flag not writable, service clears
      wr(ADR_TL0, 8'hff);
      wr(ADR_TH0, 8'hff);
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h15);
      repeat (30) @(posedge clk_i);
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h05);
      rd(ADR_TIMER_CONTROL_FLAGS);
      check(8'h25);
      rd(ADR_TH0);
      check(8'h00);
      got = {3'h0, flags};
      check(8'h04);
      pulse_ack(5'b00100);
      rd(ADR_TIMER_CONTROL_FLAGS);
      check(8'h05);
      // all three units count pin edges at full rate
      wr(ADR_TIMER_MODE_SELECT, 8'h55);
      foreach (cnt_adr[i]) wr(cnt_adr[i], 8'h00);
      wr(ADR_TIMER2_CONTROL, 8'h06);
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h55);
      src_en <= 1'b1;
      repeat (240) @(posedge clk_i);
      src_en <= 1'b0;
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h05);
      wr(ADR_TIMER2_CONTROL, 8'h00);
      foreach (cnt_adr[i]) begin
         rd(cnt_adr[i]);
         check_rng(8'd9, 8'd10);
      end
      // gate pin low stops timer 0, edge sets its flag
      wr(ADR_TIMER_MODE_SELECT, 8'h09);
      wr(ADR_TL0, 8'h00);
      ex0 <= 1'b0;
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h15);
      repeat (120) @(posedge clk_i);
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h05);
      rd(ADR_TL0);
      check(8'h00);
      rd(ADR_TIMER_CONTROL_FLAGS);
      check(8'h07);
      pulse_ack(5'b00001);
      rd(ADR_TIMER_CONTROL_FLAGS);
      check(8'h05);
      // level mode re-sets a serviced flag while low
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h00);
      ex1 <= 1'b0;
      pulse_ack(5'b00010);
      rd(ADR_TIMER_CONTROL_FLAGS);
      check(8'h0a);
      ex0 <= 1'b1;
      ex1 <= 1'b1;
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h05);
      repeat (6) @(posedge clk_i);
      pulse_ack(5'b00011);
      rd(ADR_TIMER_CONTROL_FLAGS);
      check(8'h05);
      // eight-bit reload from high byte
      wr(ADR_TIMER_MODE_SELECT, 8'h02);
      wr(ADR_TH0, 8'hf0);
      wr(ADR_TL0, 8'hfe);
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h15);
      repeat (60) @(posedge clk_i);
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h05);
      rd(ADR_TL0);
      check_rng(8'hf1, 8'hf4);
      rd(ADR_TH0);
      check(8'hf0);
      rd(ADR_TIMER_CONTROL_FLAGS);
      check(8'h25);
      // split mode: high byte runs on timer 1 run bit
      wr(ADR_TIMER_MODE_SELECT, 8'h03);
      wr(ADR_TL0, 8'h00);
      wr(ADR_TH0, 8'hfe);
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h45);
      repeat (60) @(posedge clk_i);
      wr(ADR_TIMER_CONTROL_FLAGS, 8'h05);
      rd(ADR_TH0);
      check_rng(8'h01, 8'h04);
      rd(ADR_TL0);
      check(8'h00);
      rd(ADR_TIMER_CONTROL_FLAGS);
      check(8'ha5);
      pulse_ack(5'b01000);
      rd(ADR_TIMER_CONTROL_FLAGS);
      check(8'h25);
      // second reset with a flag standing
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_TIMER_CONTROL_FLAGS);
      check(8'h00);
      got = {3'h0, flags};
      check(8'h00);
      conclude();
   end
endmodule
